// File: gpio_pin_interrupt_port.sv
// GPIO port group with pin multiplexing, loopback and pin-interrupt channels
`timescale 1ns/1ns
module gpio_pin_interrupt_port
  import gpio_pin_irq_unit_pkg::*;
#(
  parameter int NUM_PORTS = 4
) (
  input  wire logic                                   clk_sys,
  input  wire logic                                   resetn,
  input  wire cmd_s                                   cmd,
  input  wire logic [NUM_PORTS*PINS_PER_PORT-1:0]     pad_in,
  output logic      [NUM_PORTS*PINS_PER_PORT-1:0]     pad_out,
  output logic      [NUM_PORTS*PINS_PER_PORT-1:0]     pad_oe,
  output logic      [NUM_PORTS*PINS_PER_PORT-1:0]     pad_ie,
  input  wire logic [NUM_PERIPH-1:0][NUM_PORTS*PINS_PER_PORT-1:0] periph_out,
  input  wire logic [NUM_PERIPH-1:0][NUM_PORTS*PINS_PER_PORT-1:0] periph_oe,
  input  wire logic [NUM_PERIPH-1:0][NUM_PORTS*PINS_PER_PORT-1:0] periph_ie,
  output logic      [NUM_PORTS*PINS_PER_PORT-1:0]     pin_state,
  output logic      [NUM_PORTS*PINS_PER_PORT-1:0]     gpio_dir,
  output logic      [NUM_PORTS*PINS_PER_PORT-1:0]     gpio_data,
  output logic      [NUM_PORTS*PINS_PER_PORT-1:0]     gpio_pend,
  output logic      [NUM_PORTS-1:0]                   gpio_irq,
  output logic      [NUM_CHANNELS-1:0][CH_PINS-1:0]   ch_pin_state,
  output logic      [NUM_CHANNELS-1:0][CH_PINS-1:0]   ch_latch,
  output logic      [NUM_CHANNELS-1:0][CH_PINS-1:0]   ch_request,
  output logic      [NUM_CHANNELS-1:0]                ch_irq
);

  localparam int NPINS = NUM_PORTS * PINS_PER_PORT;
  localparam int NHALF = NUM_PORTS * 2;

  // The 3-bit half-port selector cannot reach beyond eight half ports
  if (NUM_PORTS < 1 || NUM_PORTS > MAX_PORTS) begin : g_bad_ports
    $error("NUM_PORTS must lie between 1 and MAX_PORTS");
  end

  // GPIO registers
  logic [NPINS-1:0]        gpio_inen;
  logic [NPINS-1:0]        gpio_mask;
  logic [NPINS-1:0]        gpio_edge;
  logic [NPINS-1:0]        gpio_both;
  logic [NPINS*FUNC_W-1:0] pin_func;

  // Channel registers
  logic [NUM_CHANNELS-1:0][ASSIGN_W-1:0] ch_assign;
  logic [NUM_CHANNELS-1:0][CH_PINS-1:0]  ch_mask;
  logic [NUM_CHANNELS-1:0][CH_PINS-1:0]  ch_edge;
  logic [NUM_CHANNELS-1:0][CH_PINS-1:0]  ch_both;
  logic [NUM_CHANNELS-1:0][CH_PINS-1:0]  ch_inv;

  // Data paths
  logic [NPINS-1:0]                     next_pad_out;
  logic [NPINS-1:0]                     next_pad_oe;
  logic [NPINS-1:0]                     next_pad_ie;
  logic [NPINS-1:0]                     rx_raw;
  logic [NPINS-1:0]                     rx_sync;
  logic [NPINS-1:0]                     gpio_src;
  logic [NPINS-1:0]                     gpio_set;
  logic [NPINS-1:0]                     gpio_clr;
  logic [NUM_CHANNELS-1:0][CH_PINS-1:0] ch_in;
  logic [NUM_CHANNELS-1:0][CH_PINS-1:0] ch_set;
  logic [NUM_CHANNELS-1:0][CH_PINS-1:0] ch_clr;

  function automatic logic hit(input cmd_s    c,
                               input target_e t,
                               input int      u);
    hit = c.valid && (c.target == t) && (int'(c.unit) == u);
  endfunction : hit

  // Picks one enabled half port for a channel lane, zero otherwise
  function automatic logic [HALF_PORT_PINS-1:0] pick_half(
      input logic [NPINS-1:0]        rx,
      input logic [LANE_FIELD_W-1:0] field);
    logic [LANE_SEL_W-1:0] sel;
    sel = field[LANE_SEL_W-1:0];
    pick_half = '0;
    if (field[LANE_EN_BIT] && int'(sel) < NHALF) begin
      pick_half = rx[int'(sel)*HALF_PORT_PINS +: HALF_PORT_PINS];
    end
  endfunction : pick_half

  // Direction register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gpio_dir <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (hit(cmd, T_DIR, p)) begin
          gpio_dir[p*PINS_PER_PORT +: PINS_PER_PORT] <=
            PINS_PER_PORT'(apply_op(
              32'(gpio_dir[p*PINS_PER_PORT +: PINS_PER_PORT]),
              cmd.op, cmd.data));
        end
      end
    end
  end

  // Output data; unselected pins keep their level on set and clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gpio_data <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (hit(cmd, T_DATA, p)) begin
          gpio_data[p*PINS_PER_PORT +: PINS_PER_PORT] <=
            PINS_PER_PORT'(apply_op(
              32'(gpio_data[p*PINS_PER_PORT +: PINS_PER_PORT]),
              cmd.op, cmd.data));
        end
      end
    end
  end

  // Input enable, interrupt mask and sensitivity of the GPIO function
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gpio_inen <= '0;
      gpio_mask <= '0;
      gpio_edge <= '0;
      gpio_both <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (hit(cmd, T_INEN, p)) begin
          gpio_inen[p*PINS_PER_PORT +: PINS_PER_PORT] <=
            PINS_PER_PORT'(apply_op(
              32'(gpio_inen[p*PINS_PER_PORT +: PINS_PER_PORT]),
              cmd.op, cmd.data));
        end
        if (hit(cmd, T_GMASK, p)) begin
          gpio_mask[p*PINS_PER_PORT +: PINS_PER_PORT] <=
            PINS_PER_PORT'(apply_op(
              32'(gpio_mask[p*PINS_PER_PORT +: PINS_PER_PORT]),
              cmd.op, cmd.data));
        end
        if (hit(cmd, T_GEDGE, p)) begin
          gpio_edge[p*PINS_PER_PORT +: PINS_PER_PORT] <=
            PINS_PER_PORT'(apply_op(
              32'(gpio_edge[p*PINS_PER_PORT +: PINS_PER_PORT]),
              cmd.op, cmd.data));
        end
        if (hit(cmd, T_GBOTH, p)) begin
          gpio_both[p*PINS_PER_PORT +: PINS_PER_PORT] <=
            PINS_PER_PORT'(apply_op(
              32'(gpio_both[p*PINS_PER_PORT +: PINS_PER_PORT]),
              cmd.op, cmd.data));
        end
      end
    end
  end

  // Function select, one half port per command unit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_func <= '0;
    end else begin
      for (int h = 0; h < NHALF; h++) begin
        if (hit(cmd, T_FUNC, h)) begin
          pin_func[h*FUNC_HALF_W +: FUNC_HALF_W] <=
            FUNC_HALF_W'(apply_op(
              32'(pin_func[h*FUNC_HALF_W +: FUNC_HALF_W]),
              cmd.op, cmd.data));
        end
      end
    end
  end

  // Exactly one owner per pin; unknown codes leave the pin idle
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      next_pad_out[i] = 1'b0;
      next_pad_oe[i]  = 1'b0;
      next_pad_ie[i]  = 1'b0;
      if (pin_func[i*FUNC_W +: FUNC_W] == FUNC_GPIO) begin
        next_pad_out[i] = gpio_data[i];
        next_pad_oe[i]  = gpio_dir[i];
        next_pad_ie[i]  = gpio_inen[i];
      end else begin
        for (int f = 1; f <= NUM_PERIPH; f++) begin
          if (int'(pin_func[i*FUNC_W +: FUNC_W]) == f) begin
            next_pad_out[i] = periph_out[f-1][i];
            next_pad_oe[i]  = periph_oe[f-1][i];
            next_pad_ie[i]  = periph_ie[f-1][i];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pad_out <= '0;
      pad_oe  <= '0;
      pad_ie  <= '0;
    end else begin
      pad_out <= next_pad_out;
      pad_oe  <= next_pad_oe;
      pad_ie  <= next_pad_ie;
    end
  end

  // Bypass takes the data ahead of the pad driver, not the pad level
  assign rx_raw = (pad_oe & pad_ie & pad_out)
                | (~(pad_oe & pad_ie) & pad_in);

  pin_sync2 #(
    .W (NPINS)
  ) u_rx_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .d       (rx_raw),
    .q       (rx_sync)
  );

  assign pin_state = rx_sync;

  // Output pins only change when software writes the data register
  assign gpio_src = (gpio_dir & gpio_data) | (~gpio_dir & rx_sync);

  always_comb begin
    gpio_set = '0;
    gpio_clr = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (hit(cmd, T_GPEND, p) && cmd.op == OP_SET) begin
        gpio_set[p*PINS_PER_PORT +: PINS_PER_PORT] =
          cmd.data[PINS_PER_PORT-1:0];
      end
      if (hit(cmd, T_GPEND, p) && cmd.op != OP_SET) begin
        gpio_clr[p*PINS_PER_PORT +: PINS_PER_PORT] =
          cmd.data[PINS_PER_PORT-1:0];
      end
    end
  end

  pin_event_latch #(
    .W (NPINS)
  ) u_gpio_det (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .sig        (gpio_src),
    .edge_mode  (gpio_edge),
    .both_edges (gpio_both),
    .invert     ({NPINS{1'b0}}),
    .set_sw     (gpio_set),
    .clr_sw     (gpio_clr),
    .latch      (gpio_pend)
  );

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gpio_irq <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        gpio_irq[p] <= |(gpio_pend[p*PINS_PER_PORT +: PINS_PER_PORT]
                       & gpio_mask[p*PINS_PER_PORT +: PINS_PER_PORT]);
      end
    end
  end

  // Channel control registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ch_assign <= {NUM_CHANNELS{RST_CH_ASSIGN}};
      ch_mask   <= '0;
      ch_edge   <= '0;
      ch_both   <= '0;
      ch_inv    <= '0;
    end else begin
      for (int c = pin_irq_channel_first; c <= pin_irq_channel_last; c++) begin
        if (hit(cmd, T_CHASSIGN, c)) begin
          ch_assign[c] <= ASSIGN_W'(apply_op(32'(ch_assign[c]),
                                             cmd.op, cmd.data));
        end
        if (hit(cmd, T_CHMASK, c)) begin
          ch_mask[c] <= apply_op(ch_mask[c], cmd.op, cmd.data);
        end
        if (hit(cmd, T_CHEDGE, c)) begin
          ch_edge[c] <= apply_op(ch_edge[c], cmd.op, cmd.data);
        end
        if (hit(cmd, T_CHBOTH, c)) begin
          ch_both[c] <= apply_op(ch_both[c], cmd.op, cmd.data);
        end
        if (hit(cmd, T_CHINV, c)) begin
          ch_inv[c] <= apply_op(ch_inv[c], cmd.op, cmd.data);
        end
      end
    end
  end

  // Channels tap the receive path, whoever owns the pin
  always_comb begin
    ch_set = '0;
    ch_clr = '0;
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      for (int l = 0; l < CH_LANES; l++) begin
        ch_in[c][l*HALF_PORT_PINS +: HALF_PORT_PINS] =
          pick_half(rx_sync,
                    ch_assign[c][l*LANE_FIELD_W +: LANE_FIELD_W]);
      end
      if (hit(cmd, T_CHLATCH, c) && cmd.op == OP_SET) begin
        ch_set[c] = cmd.data;
      end
      if (hit(cmd, T_CHLATCH, c) && cmd.op != OP_SET) begin
        ch_clr[c] = cmd.data;
      end
    end
  end

  for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
    pin_event_latch #(
      .W (CH_PINS)
    ) u_ch_det (
      .clk_sys    (clk_sys),
      .resetn     (resetn),
      .sig        (ch_in[c]),
      .edge_mode  (ch_edge[c]),
      .both_edges (ch_both[c]),
      .invert     (ch_inv[c]),
      .set_sw     (ch_set[c]),
      .clr_sw     (ch_clr[c]),
      .latch      (ch_latch[c])
    );
  end

  // Masking gates only the request, never the latch itself
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ch_pin_state <= '0;
      ch_request   <= '0;
      ch_irq       <= '0;
    end else begin
      for (int c = 0; c < NUM_CHANNELS; c++) begin
        ch_pin_state[c] <= ch_in[c];
        ch_request[c]   <= ch_latch[c] & ch_mask[c];
        ch_irq[c]       <= |(ch_latch[c] & ch_mask[c]);
      end
    end
  end

endmodule : gpio_pin_interrupt_port

// File: gpio_pin_irq_unit_pkg.sv
// Shared constants, command types and helpers for the GPIO pin-interrupt port
package gpio_pin_irq_unit_pkg;

  localparam int PINS_PER_PORT  = 16;
  localparam int HALF_PORT_PINS = 8;
  localparam int MAX_PORTS      = 4;
  localparam int NUM_CHANNELS   = 6;
  localparam int pin_irq_channel_first = 0;
  localparam int pin_irq_channel_last  = 5;
  localparam int CH_PINS        = 32;
  localparam int CH_LANES       = 4;
  localparam int LANE_FIELD_W   = 4;
  localparam int LANE_SEL_W     = 3;
  localparam int LANE_EN_BIT    = 3;
  localparam int ASSIGN_W       = 16;
  localparam int FUNC_W         = 3;
  localparam int NUM_PERIPH     = 5;
  localparam int FUNC_HALF_W    = 24;
  localparam int CMD_UNIT_W     = 4;
  localparam int CMD_DATA_W     = 32;

  localparam logic [FUNC_W-1:0]     FUNC_GPIO     = 3'h0;
  localparam logic [CMD_DATA_W-1:0] RST_WORD      = 32'h00000000;
  localparam logic [ASSIGN_W-1:0]   RST_CH_ASSIGN = 16'h0000;

  typedef enum logic [3:0] {
    T_DIR, T_DATA, T_INEN, T_GMASK, T_GEDGE, T_GBOTH, T_GPEND, T_FUNC,
    T_CHASSIGN, T_CHMASK, T_CHEDGE, T_CHBOTH, T_CHINV, T_CHLATCH
  } target_e;

  typedef enum logic [1:0] {OP_WRITE, OP_SET, OP_CLEAR} op_e;

  typedef struct packed {
    logic                  valid;
    target_e               target;
    op_e                   op;
    logic [CMD_UNIT_W-1:0] unit;
    logic [CMD_DATA_W-1:0] data;
  } cmd_s;

  // Plain write, write-one-to-set or write-one-to-clear on a register image
  function automatic logic [31:0] apply_op(input logic [31:0] cur,
                                           input op_e         op,
                                           input logic [31:0] d);
    case (op)
      OP_SET:   apply_op = cur | d;
      OP_CLEAR: apply_op = cur & ~d;
      default:  apply_op = d;
    endcase
  endfunction : apply_op

endpackage : gpio_pin_irq_unit_pkg

// File: pin_sync2.sv
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ns
module pin_sync2 #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : pin_sync2

// File: pin_event_latch.sv
// Per-bit level/edge detector with sticky request latches
`timescale 1ns/1ns
module pin_event_latch #(
  parameter int W = 32
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic [W-1:0] sig,
  input  wire logic [W-1:0] edge_mode,
  input  wire logic [W-1:0] both_edges,
  input  wire logic [W-1:0] invert,
  input  wire logic [W-1:0] set_sw,
  input  wire logic [W-1:0] clr_sw,
  output logic      [W-1:0] latch
);

  logic [W-1:0] active;
  logic [W-1:0] prev;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  logic [W-1:0] event_now;

  assign active    = sig ^ invert;
  assign rise      = active & ~prev;
  assign fall      = ~active & prev;
  assign event_now = (edge_mode & (rise | (both_edges & fall)))
                   | (~edge_mode & active);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prev <= '0;
    end else begin
      prev <= active;
    end
  end

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      latch <= '0;
    end else begin
      latch <= (latch & ~clr_sw) | set_sw | event_now;
    end
  end

endmodule : pin_event_latch

// File: gpio_port_props.sv
// Concurrent checks on the ports of the GPIO pin-interrupt port
`timescale 1ns/1ns
module gpio_port_props
  import gpio_pin_irq_unit_pkg::*;
#(
  parameter int NUM_PORTS = 4
) (
  input wire logic                                 clk_sys,
  input wire logic                                 resetn,
  input wire cmd_s                                 cmd,
  input wire logic [NUM_PORTS*PINS_PER_PORT-1:0]   pad_in,
  input wire logic [NUM_PORTS*PINS_PER_PORT-1:0]   pad_out,
  input wire logic [NUM_PORTS*PINS_PER_PORT-1:0]   pad_oe,
  input wire logic [NUM_PORTS*PINS_PER_PORT-1:0]   pad_ie,
  input wire logic [NUM_PORTS*PINS_PER_PORT-1:0]   pin_state,
  input wire logic [NUM_PORTS*PINS_PER_PORT-1:0]   gpio_dir,
  input wire logic [NUM_PORTS*PINS_PER_PORT-1:0]   gpio_data,
  input wire logic [NUM_PORTS*PINS_PER_PORT-1:0]   gpio_pend,
  input wire logic [NUM_PORTS-1:0]                 gpio_irq,
  input wire logic [NUM_CHANNELS-1:0][CH_PINS-1:0] ch_latch,
  input wire logic [NUM_CHANNELS-1:0][CH_PINS-1:0] ch_request,
  input wire logic [NUM_CHANNELS-1:0]              ch_irq
);
  logic [1:0]                             since_rst;
  logic [NUM_PORTS*PINS_PER_PORT-1:0]     rx;

  // Receive path as the pads present it, loopback included
  assign rx = (pad_oe & pad_ie & pad_out) | (~(pad_oe & pad_ie) & pad_in);

  // The sync pipeline holds reset values for its first edges
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      since_rst <= 2'h0;
    end else if (since_rst != 2'h3) begin
      since_rst <= since_rst + 2'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_dir_wr;
    cmd.valid && cmd.target == T_DIR && cmd.op == OP_WRITE && cmd.unit == 4'h0;
  endsequence
  sequence s_data_set;
    cmd.valid && cmd.target == T_DATA && cmd.op == OP_SET && cmd.unit == 4'h0;
  endsequence
  sequence s_data_clr;
    cmd.valid && cmd.target == T_DATA && cmd.op == OP_CLEAR
      && cmd.unit == 4'h0;
  endsequence
  sequence s_no_latch_cmd;
    !(cmd.valid && cmd.target == T_CHLATCH && cmd.unit == 4'h0);
  endsequence

  a_dir_write: assert property (
    s_dir_wr |=> gpio_dir[15:0] == $past(cmd.data[15:0]))
    else $error("direction write not taken");
  a_data_set: assert property (
    s_data_set |=> gpio_data[15:0] ==
      ($past(gpio_data[15:0]) | $past(cmd.data[15:0])))
    else $error("output set disturbed other pins");
  a_data_clear: assert property (
    s_data_clr |=> gpio_data[15:0] ==
      ($past(gpio_data[15:0]) & ~$past(cmd.data[15:0])))
    else $error("output clear disturbed other pins");
  a_sync_two_stage: assert property (
    since_rst == 2'h3 |-> pin_state == $past(rx, 2))
    else $error("pin state not two cycles behind receive path");
  a_latch_sticky: assert property (
    s_no_latch_cmd |=> ($past(ch_latch[0]) & ~ch_latch[0]) == '0)
    else $error("channel latch dropped without a clear");
  a_mask_gates: assert property (
    (ch_request[0] & ~$past(ch_latch[0])) == '0)
    else $error("request without a latched event");
  a_chan_irq: assert property (
    ch_irq[0] == |ch_request[0] && ch_irq[5] == |ch_request[5])
    else $error("channel irq does not match requests");
  a_gpio_irq: assert property (
    $rose(gpio_irq[0]) |-> $past(|gpio_pend[15:0]))
    else $error("port irq without pending pin");
endmodule : gpio_port_props

bind gpio_pin_interrupt_port gpio_port_props #(.NUM_PORTS(NUM_PORTS)) u_props (
  .clk_sys(clk_sys), .resetn(resetn), .cmd(cmd), .pad_in(pad_in),
  .pad_out(pad_out), .pad_oe(pad_oe), .pad_ie(pad_ie),
  .pin_state(pin_state), .gpio_dir(gpio_dir), .gpio_data(gpio_data),
  .gpio_pend(gpio_pend), .gpio_irq(gpio_irq), .ch_latch(ch_latch),
  .ch_request(ch_request), .ch_irq(ch_irq));

// File: pin_world.sv
// External pads and the five peripheral functions facing the port
`timescale 1ns/1ns
module pin_world
  import gpio_pin_irq_unit_pkg::*;
#(
  parameter int NPINS = 16
) (
  input  wire logic [NPINS-1:0]                 pad_out,
  input  wire logic [NPINS-1:0]                 pad_oe,
  input  wire logic [NPINS-1:0]                 ext_level,
  input  wire logic [NPINS-1:0]                 overdrive,
  output logic      [NPINS-1:0]                 pad_in,
  output logic      [NUM_PERIPH-1:0][NPINS-1:0] periph_out,
  output logic      [NUM_PERIPH-1:0][NPINS-1:0] periph_oe,
  output logic      [NUM_PERIPH-1:0][NPINS-1:0] periph_ie
);
  // A driven pad reads back its own level unless a stronger source wins
  assign pad_in = (pad_oe & ~overdrive & pad_out)
                | ((~pad_oe | overdrive) & ext_level);

  // Function f drives only pin f-1 high so a wrong selection shows
  always_comb begin
    for (int i = 0; i < NUM_PERIPH; i++) begin
      periph_out[i] = NPINS'(1) << i;
      periph_oe[i]  = '1;
      periph_ie[i]  = '0;
    end
  end
endmodule : pin_world

// File: testbench.sv
// Directed bench for the GPIO pin-interrupt port
`timescale 1ns/1ns
module testbench;
  import gpio_pin_irq_unit_pkg::*;
  localparam int NP = 16;
  logic                                 clk_sys;
  logic                                 resetn;
  cmd_s                                 cmd;
  logic [NP-1:0]                        pad_in, pad_out, pad_oe, pad_ie;
  logic [NP-1:0]                        ext_level, overdrive, pin_state;
  logic [NP-1:0]                        gpio_dir, gpio_data, gpio_pend;
  logic [NUM_PERIPH-1:0][NP-1:0]        periph_out, periph_oe, periph_ie;
  logic [0:0]                           gpio_irq;
  logic [NUM_CHANNELS-1:0][CH_PINS-1:0] ch_pin_state, ch_latch, ch_request;
  logic [NUM_CHANNELS-1:0]              ch_irq;
  logic [2:0]                           fc;
  int                                   err_count, n_checks, cyc;

  gpio_pin_interrupt_port #(.NUM_PORTS(1)) dut (
    .clk_sys(clk_sys), .resetn(resetn), .cmd(cmd), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_ie(pad_ie),
    .periph_out(periph_out), .periph_oe(periph_oe), .periph_ie(periph_ie),
    .pin_state(pin_state), .gpio_dir(gpio_dir), .gpio_data(gpio_data),
    .gpio_pend(gpio_pend), .gpio_irq(gpio_irq), .ch_pin_state(ch_pin_state),
    .ch_latch(ch_latch), .ch_request(ch_request), .ch_irq(ch_irq));

  pin_world #(.NPINS(NP)) u_world (
    .pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level),
    .overdrive(overdrive), .pad_in(pad_in), .periph_out(periph_out),
    .periph_oe(periph_oe), .periph_ie(periph_ie));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // One idle cycle follows each command so valid never toggles twice
  task automatic put(input target_e t, input op_e o, input int u,
                     input logic [31:0] d);
    @(posedge clk_sys);
    cmd <= '{valid: 1'b1, target: t, op: o, unit: 4'(u), data: d};
    @(posedge clk_sys);
    cmd.valid <= 1'b0;
  endtask : put

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic pin(input int n, input logic v);
    @(posedge clk_sys);
    ext_level[n] <= v;
  endtask : pin

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end

  initial begin
    resetn = 1'b0; cmd = '0; ext_level = '0; overdrive = '0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    settle(1);
    check("dir_rst", 32'(gpio_dir), 32'h0);
    put(T_DIR, OP_WRITE, 0, 32'h000000FF);
    put(T_DATA, OP_SET, 0, 32'h00000005);
    put(T_DATA, OP_SET, 0, 32'h00000030);
    put(T_DATA, OP_CLEAR, 0, 32'h00000001);
    put(T_DIR, OP_SET, 0, 32'h00000100);
    put(T_DIR, OP_CLEAR, 0, 32'h00000001);
    put(T_DIR, OP_WRITE, 1, 32'h0000FFFF);
    settle(2);
    check("dir", 32'(gpio_dir), 32'h01FE);
    check("data", 32'(gpio_data), 32'h0034);
    check("pad_oe", 32'(pad_oe), 32'h01FE);
    check("pad_out", 32'(pad_out & pad_oe), 32'h0034);
    $display("test ports done");
    for (int f = 1; f < 8; f++) begin
      fc = 3'(f);
      put(T_FUNC, OP_WRITE, 0, 32'({8{fc}}));
      settle(2);
      check("mux_out", 32'(pad_out[7:0]),
            f < 6 ? 32'(1) << (f - 1) : 32'h0);
      check("mux_oe", 32'(pad_oe[7:0]), f < 6 ? 32'hFF : 32'h0);
    end
    put(T_FUNC, OP_WRITE, 0, 32'h0);
    put(T_FUNC, OP_WRITE, 1, 32'h00DB6DB6);
    $display("test mux done");
    ext_level[1] <= 1'b1;
    overdrive[1] <= 1'b1;
    settle(5);
    check("no_loop", 32'(pin_state[1]), 32'h1);
    put(T_INEN, OP_SET, 0, 32'h2);
    settle(5);
    check("loop", 32'(pin_state[1]), 32'h0);
    check("pad_ie", 32'(pad_ie), 32'h0002);
    $display("test loopback done");
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      put(T_CHASSIGN, OP_WRITE, c, 32'h9);
    end
    pin(8, 1'b1);
    settle(5);
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      check("ch_state", 32'(ch_pin_state[c][1:0]), 32'h1);
      check("ch_latch", 32'(ch_latch[c][8:0]), 32'h1);
      check("ch_masked", 32'(ch_irq[c]), 32'h0);
    end
    put(T_CHMASK, OP_SET, 0, 32'h1);
    settle(3);
    check("ch_req", ch_request[0], 32'h1);
    check("ch_irq", 32'(ch_irq[0]), 32'h1);
    put(T_CHEDGE, OP_SET, 0, 32'h1);
    put(T_CHLATCH, OP_CLEAR, 0, 32'h1);
    settle(3);
    check("edge_clr", ch_latch[0], 32'h0);
    pin(8, 1'b0);
    settle(5);
    check("rise_only", ch_latch[0], 32'h0);
    put(T_CHBOTH, OP_SET, 0, 32'h1);
    pin(8, 1'b1);
    settle(5);
    check("rise", ch_latch[0], 32'h1);
    put(T_CHLATCH, OP_CLEAR, 0, 32'h1);
    pin(8, 1'b0);
    settle(5);
    check("fall", ch_latch[0], 32'h1);
    put(T_CHEDGE, OP_CLEAR, 0, 32'h1);
    put(T_CHINV, OP_SET, 0, 32'h1);
    put(T_CHLATCH, OP_CLEAR, 0, 32'h1);
    settle(3);
    check("inv_level", ch_latch[0], 32'h1);
    // Software force on a lane that is disabled, so only the force can set it
    put(T_CHLATCH, OP_SET, 0, 32'h80000000);
    settle(2);
    check("latch_force", ch_latch[0], 32'h80000001);
    $display("test channels done");
    put(T_GEDGE, OP_SET, 0, 32'h0204);
    put(T_GPEND, OP_CLEAR, 0, 32'h0204);
    put(T_GMASK, OP_SET, 0, 32'h0204);
    pin(9, 1'b1);
    settle(5);
    check("pend_in", 32'(gpio_pend & 16'h0204), 32'h0200);
    check("irq_in", 32'(gpio_irq), 32'h1);
    put(T_GPEND, OP_CLEAR, 0, 32'h0200);
    settle(3);
    check("irq_clr", 32'(gpio_irq), 32'h0);
    put(T_DATA, OP_CLEAR, 0, 32'h4);
    put(T_DATA, OP_SET, 0, 32'h4);
    settle(4);
    check("pend_sw", 32'(gpio_pend & 16'h0204), 32'h0004);
    check("irq_sw", 32'(gpio_irq), 32'h1);
    put(T_GPEND, OP_SET, 0, 32'h8000);
    settle(2);
    check("pend_force", 32'(gpio_pend & 16'h8204), 32'h8004);
    $display("test gpio irq done");
    results();
  end
endmodule : testbench
